//--- rtl/irqef_defines.svh
/*
  Offsets, field positions and reset values of the interrupt enable and fault flag registers.
  Assumes inclusion by bare name from design files.
*/
`ifndef IRQEF_DEFINES_SVH
`define IRQEF_DEFINES_SVH

`define IRQEF_ADDR_W 7
`define IRQEF_OFF_ENABLE_LOW 7'h08
`define IRQEF_OFF_ENABLE_HIGH 7'h09
`define IRQEF_OFF_FAULT_FLAGS 7'h0A
`define IRQEF_RESET_ENABLE_LOW 8'h00
`define IRQEF_RESET_ENABLE_HIGH 8'h00
`define IRQEF_RESET_FAULT_FLAGS 8'h00

`define IRQEF_BIT_POLARITY_INVERT 7
`define IRQEF_BIT_PIN_DRIVE_STYLE 7
`define IRQEF_BIT_PIN_OUTPUT_GATE 6
`define IRQEF_BIT_CARD_DETECT_GATE 5

`define IRQEF_BIT_EEPROM_FAULT 7
`define IRQEF_BIT_BUFFER_WRITE_FAULT 6
`define IRQEF_BIT_BUFFER_OVERFLOW 5
`define IRQEF_BIT_SHORT_FRAME_FAULT 4
`define IRQEF_BIT_EMPTY_TRANSMIT_FAULT 3
`define IRQEF_BIT_COLLISION_SEEN 2
`define IRQEF_BIT_FRAMING_FAULT 1
`define IRQEF_BIT_INTEGRITY_FAULT 0

`define IRQEF_MIN_FRAME_BITS 4
`define IRQEF_MIN_EMD_BYTES 3

`endif

//--- rtl/irqef_pkg.sv
/*
  Types shared by the interrupt enable and fault flag block.
  Assumes the defines header is compiled alongside.
*/
package irqef_pkg;
  typedef logic [7:0] irqef_byte_t;
  typedef logic [6:0] irqef_addr_t;
  typedef logic [10:0] irqef_pos_t;
  typedef enum logic [1:0] {
    IRQEF_CMD_OTHER,
    IRQEF_CMD_RECEIVE,
    IRQEF_CMD_TRANSCEIVE
  } irqef_cmd_e;
endpackage : irqef_pkg

//--- rtl/irqef_sticky_flag.sv
/*
  One sticky fault flag: a set wins over a clear in the same cycle.
  Assumes single clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module irqef_sticky_flag (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic setEvent,
  input wire logic clearEvent,
  // State
  output logic flag
);
  import irqef_pkg::*;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (setEvent) begin
      flag <= 1'b1;
    end else if (clearEvent) begin
      flag <= 1'b0;
    end
  end
endmodule : irqef_sticky_flag

//--- rtl/irqef_top.sv
/*
  Interrupt enable registers, combined request, interrupt pin driver and contactless fault flags.
  Assumes a simple synchronous register port from the host interface block and event strobes
  from the transceiver, FIFO, EEPROM and decoder logic, all on clk_sys.
*/
`timescale 1ns/1ps
`include "irqef_defines.svh"

// Functional notes
// - Polarity bit inverts interrupt pin level
// - Low enable bits gate seven request flags
// - High bits 4..0 gate timer requests
// - High bit 5 gates card detect request
// - High bit 7 selects push-pull or open-drain
// - Pin enable passes combined request to pin
// - Failed EEPROM command sets fault bit 7
// - FIFO write in busy states sets bit 6
// - Bit 6 clears at command or store
// - Write to full FIFO sets bit 5
// - Overflow set discards later FIFO writes
// - Under four bits after start sets bit 4
// - Short frame dropped, no receive request
// - EMD on: under three bytes dropped too
// - Bit 4 clears at receive phase start
// - Transmit with empty FIFO sets bit 3
// - Collision sets bit 2, records position
// - Bit 2 clears at receive phase start
// - Collision in end symbol is ignored
// - Enabled set request raises combined request
// - Fault request follows five fault flags
// - Bit 1 framing fault stops reception
// - Bit 0 integrity fault, reception continues
module irqef_top #(
  parameter int POS_W = 11
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire irqef_pkg::irqef_addr_t regAddr,
  input wire irqef_pkg::irqef_byte_t regWdata,
  output irqef_pkg::irqef_byte_t regRdata,
  // Request flags from the request registers
  input wire logic [6:0] lowRequests,
  input wire logic [5:0] highRequests,
  // Command sequencing
  input wire logic cmdStart,
  input wire irqef_pkg::irqef_cmd_e cmdKind,
  input wire logic waitDataEnter,
  input wire logic multiFrameReceive,
  input wire logic faultsStored,
  // FIFO write path
  input wire logic fifoWriteReq,
  input wire logic fifoFull,
  input wire logic fifoEmpty,
  input wire logic busyForWrite,
  output logic fifoWriteAccept,
  // Events
  input wire logic eepromCmdDone,
  input wire logic eepromCmdFailed,
  input wire logic transmitDue,
  input wire logic frameEnd,
  input wire logic [3:0] frameBitCount,
  input wire logic [2:0] frameByteCount,
  input wire logic emdSuppress,
  input wire logic collisionEvent,
  input wire logic collisionInEof,
  input wire logic [POS_W-1:0] collisionPos,
  input wire logic framingEvent,
  input wire logic integrityEvent,
  // Receiver results
  output logic receiveDoneOk,
  output logic stopReception,
  output logic [POS_W-1:0] collision_position_reg,
  // Requests and pin
  output logic combined_request,
  output logic fault_request,
  output logic irqPinOut,
  output logic irqPinOe
);
  import irqef_pkg::*;

  // ----------------------------------------
  // Registers and flags
  // ----------------------------------------
  irqef_byte_t request_enable_low;
  irqef_byte_t request_enable_high;
  logic eeprom_fault;
  logic buffer_write_fault;
  logic buffer_overflow;
  logic short_frame_fault;
  logic empty_transmit_fault;
  logic collision_seen;
  logic framing_fault;
  logic integrity_fault;
  logic collisionFirst;
  logic rxPhaseStart;
  logic cmdAnyStart;
  logic shortBits;
  logic shortBytes;
  logic fifoWriteBad;
  logic collisionSet;
  logic [6:0] lowMasked;
  logic [5:0] highMasked;
  logic pinActive;
  irqef_byte_t faultFlags;

  // ----------------------------------------
  // Enable register writes
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_enable_low <= `IRQEF_RESET_ENABLE_LOW;
    end else if (regWrite && regAddr == `IRQEF_OFF_ENABLE_LOW) begin
      request_enable_low <= regWdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_enable_high <= `IRQEF_RESET_ENABLE_HIGH;
    end else if (regWrite && regAddr == `IRQEF_OFF_ENABLE_HIGH) begin
      request_enable_high <= regWdata;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `IRQEF_OFF_ENABLE_LOW) begin
        regRdata <= request_enable_low;
      end else if (regAddr == `IRQEF_OFF_ENABLE_HIGH) begin
        regRdata <= request_enable_high;
      end else if (regAddr == `IRQEF_OFF_FAULT_FLAGS) begin
        regRdata <= faultFlags;
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Combined request and pin
  // ----------------------------------------
  always_comb begin
    lowMasked = lowRequests & request_enable_low[6:0];
    highMasked = highRequests & request_enable_high[5:0];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      combined_request <= 1'b0;
    end else begin
      combined_request <= (|lowMasked) | (|highMasked);
    end
  end

  assign pinActive = (combined_request & request_enable_high[`IRQEF_BIT_PIN_OUTPUT_GATE])
    ^ request_enable_low[`IRQEF_BIT_POLARITY_INVERT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqPinOut <= 1'b0;
      irqPinOe <= 1'b0;
    end else if (request_enable_high[`IRQEF_BIT_PIN_DRIVE_STYLE]) begin
      irqPinOut <= pinActive;
      irqPinOe <= 1'b1;
    end else begin
      irqPinOut <= 1'b0;
      irqPinOe <= ~pinActive;
    end
  end

  // ----------------------------------------
  // Fault event decode
  // ----------------------------------------
  assign cmdAnyStart = cmdStart;
  assign rxPhaseStart = (cmdStart && cmdKind == IRQEF_CMD_RECEIVE)
    || (waitDataEnter && cmdKind == IRQEF_CMD_TRANSCEIVE);
  assign fifoWriteBad = fifoWriteReq && busyForWrite;
  assign fifoWriteAccept = fifoWriteReq && !fifoFull && !buffer_overflow;
  assign shortBits = frameEnd && (frameBitCount < 4'(`IRQEF_MIN_FRAME_BITS));
  assign shortBytes = frameEnd && emdSuppress
    && (frameByteCount < 3'(`IRQEF_MIN_EMD_BYTES));
  assign collisionSet = collisionEvent && !collisionInEof;
  assign receiveDoneOk = frameEnd && !shortBits && !shortBytes;
  assign stopReception = framingEvent;

  // ----------------------------------------
  // Sticky fault flags
  // ----------------------------------------
  irqef_sticky_flag u_eeprom (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(eepromCmdDone && eepromCmdFailed),
    .clearEvent(eepromCmdDone && !eepromCmdFailed),
    .flag(eeprom_fault)
  );

  irqef_sticky_flag u_write (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(fifoWriteBad),
    .clearEvent(multiFrameReceive ? faultsStored : cmdAnyStart),
    .flag(buffer_write_fault)
  );

  irqef_sticky_flag u_overflow (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(fifoWriteReq && fifoFull),
    .clearEvent(cmdAnyStart),
    .flag(buffer_overflow)
  );

  irqef_sticky_flag u_short (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(shortBits),
    .clearEvent(rxPhaseStart),
    .flag(short_frame_fault)
  );

  irqef_sticky_flag u_empty (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(transmitDue && fifoEmpty),
    .clearEvent(cmdAnyStart),
    .flag(empty_transmit_fault)
  );

  irqef_sticky_flag u_collision (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(collisionSet),
    .clearEvent(rxPhaseStart),
    .flag(collision_seen)
  );

  irqef_sticky_flag u_framing (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(framingEvent),
    .clearEvent(rxPhaseStart),
    .flag(framing_fault)
  );

  irqef_sticky_flag u_integrity (
    .clk_sys(clk_sys),
    .rst(rst),
    .setEvent(integrityEvent),
    .clearEvent(rxPhaseStart),
    .flag(integrity_fault)
  );

  // ----------------------------------------
  // Collision position capture
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      collisionFirst <= 1'b1;
      collision_position_reg <= '0;
    end else if (collisionSet && collisionFirst) begin
      collisionFirst <= 1'b0;
      collision_position_reg <= collisionPos;
    end else if (rxPhaseStart) begin
      collisionFirst <= 1'b1;
    end
  end

  // ----------------------------------------
  // Fault summary
  // ----------------------------------------
  always_comb begin
    faultFlags = `IRQEF_RESET_FAULT_FLAGS;
    faultFlags[`IRQEF_BIT_EEPROM_FAULT] = eeprom_fault;
    faultFlags[`IRQEF_BIT_BUFFER_WRITE_FAULT] = buffer_write_fault;
    faultFlags[`IRQEF_BIT_BUFFER_OVERFLOW] = buffer_overflow;
    faultFlags[`IRQEF_BIT_SHORT_FRAME_FAULT] = short_frame_fault;
    faultFlags[`IRQEF_BIT_EMPTY_TRANSMIT_FAULT] = empty_transmit_fault;
    faultFlags[`IRQEF_BIT_COLLISION_SEEN] = collision_seen;
    faultFlags[`IRQEF_BIT_FRAMING_FAULT] = framing_fault;
    faultFlags[`IRQEF_BIT_INTEGRITY_FAULT] = integrity_fault;
  end

  assign fault_request = buffer_write_fault | buffer_overflow | framing_fault
    | empty_transmit_fault | integrity_fault;
endmodule : irqef_top

//--- testbench/irqef_checker_sva.sv
/*
  Concurrent checks on the interrupt enable and fault flag block.
  Assumes binding to irqef_top and sight of its ports only.
*/
`timescale 1ns/1ps
module irqef_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire irqef_pkg::irqef_addr_t regAddr,
  input wire irqef_pkg::irqef_byte_t regWdata,
  input wire irqef_pkg::irqef_byte_t regRdata,
  // Requests and pin
  input wire logic [6:0] lowRequests,
  input wire logic [5:0] highRequests,
  input wire logic combined_request,
  input wire logic fault_request,
  input wire logic irqPinOut,
  input wire logic irqPinOe,
  // Fault events
  input wire logic fifoWriteReq,
  input wire logic fifoFull,
  input wire logic fifoEmpty,
  input wire logic fifoWriteAccept,
  input wire logic transmitDue,
  input wire logic framingEvent,
  input wire logic stopReception,
  input wire logic frameEnd,
  input wire logic [3:0] frameBitCount,
  input wire logic [2:0] frameByteCount,
  input wire logic emdSuppress,
  input wire logic receiveDoneOk
);
  import irqef_pkg::*;
  irqef_byte_t lowEn_reg;
  irqef_byte_t highEn_reg;
  irqef_byte_t readExp;
  logic pinLevel;
  // ----------------------------------------
  // Shadow enables
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowEn_reg <= 8'h00;
      highEn_reg <= 8'h00;
    end else if (regWrite && regAddr == 7'h08) begin
      lowEn_reg <= regWdata;
    end else if (regWrite && regAddr == 7'h09) begin
      highEn_reg <= regWdata;
    end
  end
  assign readExp = (regAddr == 7'h08) ? lowEn_reg : ((regAddr == 7'h09) ? highEn_reg : 8'h00);
  assign pinLevel = irqPinOe ? irqPinOut : 1'b1;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_COMBINED: assert property (
    combined_request == $past(|(lowRequests & lowEn_reg[6:0]) || |(highRequests & highEn_reg[5:0])))
    else $error("combined request wrong");
  AST_PIN_LEVEL: assert property (
    !$past(rst) |-> pinLevel == $past((combined_request && highEn_reg[6]) ^ lowEn_reg[7]))
    else $error("pin level wrong");
  AST_DRIVE_STYLE: assert property (
    !$past(rst) |-> ($past(highEn_reg[7]) ? irqPinOe : !irqPinOut))
    else $error("pin drive style wrong");
  AST_READBACK: assert property (
    regRead && regAddr != 7'h0A |=> regRdata == $past(readExp))
    else $error("enable readback wrong");
  AST_FULL_REFUSED: assert property (
    fifoWriteReq && fifoFull |-> !fifoWriteAccept ##1 !fifoWriteAccept)
    else $error("write to full buffer accepted");
  AST_STOP: assert property (
    stopReception == framingEvent)
    else $error("reception stop wrong");
  AST_FRAMING_FLAG: assert property (
    framingEvent |=> fault_request)
    else $error("framing fault not flagged");
  AST_SHORT_FRAME: assert property (
    frameEnd |-> receiveDoneOk == !(frameBitCount < 4'h4 || (emdSuppress && frameByteCount < 3'h3)))
    else $error("short frame handling wrong");
  AST_EMPTY_TX: assert property (
    transmitDue && fifoEmpty |=> fault_request)
    else $error("empty transmit not flagged");
endmodule : irqef_checker

bind irqef_top irqef_checker u_checker (.*);

//--- testbench/irqef_host_model.sv
/*
  Host side of the interrupt pin, with the external pull-up.
  Assumes the pin is released whenever its output enable is low.
*/
`timescale 1ns/1ps
module irqef_host_model (
  // Pin drive from the device
  input wire logic irqPinOut,
  input wire logic irqPinOe,
  // Level seen by the host
  output logic pinLevel
);
  // Released pin rises to the pull-up level
  assign pinLevel = irqPinOe ? irqPinOut : 1'b1;
endmodule : irqef_host_model

//--- testbench/tb_top.sv
/*
  Self-checking bench: enables, pin drive and fault flags of irqef_top.
  Assumes the package, header and checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nFail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import irqef_pkg::*;
  logic clk_sys, rst, regWrite, regRead, cmdStart, waitDataEnter, multiFrameReceive, faultsStored;
  logic fifoWriteReq, fifoFull, fifoEmpty, busyForWrite, fifoWriteAccept, eepromCmdDone, eepromCmdFailed;
  logic transmitDue, frameEnd, emdSuppress, collisionEvent, collisionInEof, framingEvent, integrityEvent;
  logic receiveDoneOk, stopReception, combined_request, fault_request, irqPinOut, irqPinOe, pinLevel;
  irqef_addr_t regAddr;
  irqef_byte_t regWdata, regRdata;
  irqef_cmd_e cmdKind;
  logic [6:0] lowRequests;
  logic [5:0] highRequests;
  logic [3:0] frameBitCount;
  logic [2:0] frameByteCount;
  logic [10:0] collisionPos, collision_position_reg;
  int nFail, checksDone;
  irqef_top #(.POS_W(11)) dut (.*);
  irqef_host_model partner (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
    step();
  endtask : pulse
  task automatic wr(input irqef_addr_t a, input irqef_byte_t d);
    regAddr = a;
    regWdata = d;
    pulse(regWrite);
  endtask : wr
  task automatic rd(input irqef_addr_t a, input irqef_byte_t e);
    regAddr = a;
    pulse(regRead);
    `CHK(regRdata, e)
  endtask : rd
  task automatic gate(input logic [6:0] lo, input logic [5:0] hi, input logic eReq, input logic ePin);
    lowRequests = lo;
    highRequests = hi;
    step();
    `CHK(combined_request, eReq)
    step();
    `CHK(pinLevel, ePin)
  endtask : gate
  task automatic frame(input logic [3:0] bits, input logic [2:0] bytes, input logic emd, input logic ok);
    frameBitCount = bits;
    frameByteCount = bytes;
    emdSuppress = emd;
    frameEnd = 1;
    #1;
    `CHK(receiveDoneOk, ok)
    step();
    frameEnd = 0;
    step();
  endtask : frame
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrapUp
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    nFail++;
    wrapUp();
  end
  initial begin
    {regWrite, regRead, cmdStart, waitDataEnter, multiFrameReceive, faultsStored, fifoWriteReq} = '0;
    {fifoFull, fifoEmpty, busyForWrite, eepromCmdDone, eepromCmdFailed, transmitDue, frameEnd} = '0;
    {emdSuppress, collisionEvent, collisionInEof, framingEvent, integrityEvent} = '0;
    {regAddr, regWdata, lowRequests, highRequests, frameBitCount, frameByteCount, collisionPos} = '0;
    cmdKind = IRQEF_CMD_OTHER;
    rst = 1;
    repeat (2) @(posedge clk_sys);
    #2;
    rst = 0;
    rd(7'h08, 8'h00);
    rd(7'h09, 8'h00);
    wr(7'h0A, 8'hFF);
    rd(7'h0A, 8'h00);
    rd(7'h30, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(7'h08, 8'(1 << i));
      wr(7'h09, 8'hC0);
      gate(7'h7F ^ 7'(1 << i), 6'h3F, 1'b0, 1'b0);
      gate(7'(1 << i), 6'h00, 1'b1, 1'b1);
    end
    wr(7'h08, 8'h00);
    for (int j = 0; j < 6; j++) begin
      wr(7'h09, 8'hC0 | 8'(1 << j));
      gate(7'h7F, 6'h3F ^ 6'(1 << j), 1'b0, 1'b0);
      gate(7'h00, 6'(1 << j), 1'b1, 1'b1);
    end
    wr(7'h09, 8'h01);
    gate(7'h00, 6'h01, 1'b1, 1'b0);
    wr(7'h08, 8'h80);
    gate(7'h00, 6'h01, 1'b1, 1'b1);
    `CHK(irqPinOe, 1'b0)
    wr(7'h09, 8'hC1);
    gate(7'h00, 6'h01, 1'b1, 1'b0);
    `CHK(irqPinOe, 1'b1)
    $display("test pin done");
    highRequests = 6'h00;
    fifoEmpty = 1;
    pulse(transmitDue);
    fifoEmpty = 0;
    `CHK(fault_request, 1'b1)
    rd(7'h0A, 8'h08);
    pulse(cmdStart);
    busyForWrite = 1;
    pulse(fifoWriteReq);
    rd(7'h0A, 8'h40);
    pulse(cmdStart);
    rd(7'h0A, 8'h00);
    multiFrameReceive = 1;
    pulse(fifoWriteReq);
    busyForWrite = 0;
    pulse(cmdStart);
    rd(7'h0A, 8'h40);
    pulse(faultsStored);
    rd(7'h0A, 8'h00);
    multiFrameReceive = 0;
    fifoFull = 1;
    fifoWriteReq = 1;
    #1;
    `CHK(fifoWriteAccept, 1'b0)
    step();
    fifoWriteReq = 0;
    fifoFull = 0;
    step();
    fifoWriteReq = 1;
    #1;
    `CHK(fifoWriteAccept, 1'b0)
    step();
    fifoWriteReq = 0;
    step();
    rd(7'h0A, 8'h20);
    pulse(cmdStart);
    eepromCmdFailed = 1;
    pulse(eepromCmdDone);
    eepromCmdFailed = 0;
    rd(7'h0A, 8'h80);
    pulse(eepromCmdDone);
    rd(7'h0A, 8'h00);
    $display("test faults done");
    frame(4'h3, 3'h7, 1'b0, 1'b0);
    rd(7'h0A, 8'h10);
    cmdKind = IRQEF_CMD_RECEIVE;
    pulse(cmdStart);
    rd(7'h0A, 8'h00);
    frame(4'h4, 3'h0, 1'b0, 1'b1);
    frame(4'hF, 3'h2, 1'b1, 1'b0);
    frame(4'h4, 3'h3, 1'b1, 1'b1);
    collisionPos = 11'h005;
    pulse(collisionEvent);
    collisionPos = 11'h009;
    pulse(collisionEvent);
    `CHK(collision_position_reg, 11'h005)
    `CHK(fault_request, 1'b0)
    rd(7'h0A, 8'h04);
    cmdKind = IRQEF_CMD_TRANSCEIVE;
    pulse(cmdStart);
    rd(7'h0A, 8'h04);
    pulse(waitDataEnter);
    rd(7'h0A, 8'h00);
    collisionInEof = 1;
    pulse(collisionEvent);
    rd(7'h0A, 8'h00);
    framingEvent = 1;
    #1;
    `CHK(stopReception, 1'b1)
    step();
    framingEvent = 0;
    pulse(integrityEvent);
    rd(7'h0A, 8'h03);
    pulse(waitDataEnter);
    rd(7'h0A, 8'h00);
    $display("test receive done");
    wrapUp();
  end
endmodule : tb_top
